// ### rscs_pkg.sv
package rscs_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [11:0] RSCS_OFS_CTRL = 12'h000;
  localparam logic [11:0] RSCS_OFS_CLK = 12'h004;
  localparam logic [11:0] RSCS_OFS_STAT = 12'h008;
  localparam logic [11:0] RSCS_OFS_MASK = 12'h00C;
  localparam logic [11:0] RSCS_OFS_WDOG = 12'h010;

  // Control register fields
  localparam int RSCS_CTRL_SWRST = 0;
  localparam int RSCS_CTRL_WDEN = 1;
  localparam int RSCS_CTRL_WDRESTART = 2;
  localparam int RSCS_CTRL_FMON = 3;
  localparam int RSCS_CTRL_UVEN = 4;

  // Status bits: sticky reset causes and failure event
  localparam int RSCS_ST_PIN = 0;
  localparam int RSCS_ST_WDOG = 1;
  localparam int RSCS_ST_SW = 2;
  localparam int RSCS_ST_DBG = 3;
  localparam int RSCS_ST_UV = 4;
  localparam int RSCS_ST_OSCF = 5;
  localparam int RSCS_NSTAT = 6;

  // Clock source select codes, reset clock settings and forced undervoltage level
  localparam logic [2:0] RSCS_SRC_RC2M = 3'h0;
  localparam logic [2:0] RSCS_SRC_RC32M = 3'h1;
  localparam logic [2:0] RSCS_SRC_RC32K = 3'h2;
  localparam logic [2:0] RSCS_SRC_XOSC = 3'h3;
  localparam logic [2:0] RSCS_SRC_PLL = 3'h4;
  localparam logic [4:0] RSCS_ENA_ULP_ONLY = 5'h10;
  localparam logic [3:0] RSCS_PRESC_RST = 4'h0;
  localparam logic [2:0] RSCS_UVLVL_LOW = 3'h7;

  // ****************************************
  // Timing
  // ****************************************
  localparam int RSCS_CLK_MHZ = 100;
  localparam int RSCS_TEXT_NS = 100;
  localparam int RSCS_TEXT_CYC = (RSCS_TEXT_NS * RSCS_CLK_MHZ + 999) / 1000;
  localparam int RSCS_RC2M_KHZ = 2000;
  localparam int RSCS_RC2M_CYC = (RSCS_CLK_MHZ * 1000) / RSCS_RC2M_KHZ;
  localparam int RSCS_WD_PULSE_CYC = RSCS_RC2M_CYC + RSCS_RC2M_CYC / 2;
  localparam int RSCS_WD_TMO_DEF = 8000;

  typedef enum logic [1:0] {
    RSCS_PIN_IDLE,
    RSCS_PIN_FILT,
    RSCS_PIN_HOLD
  } rscs_pin_e;

  typedef struct packed {
    logic [2:0] sel;
    logic [3:0] presc;
    logic [4:0] src_en;
  } rscs_clk_s;

  typedef struct packed {
    logic pin;
    logic wdog;
    logic sw;
    logic dbg;
    logic uv;
  } rscs_src_s;

endpackage : rscs_pkg

// ### rscs_top.sv
// The register addresses and register access over APB were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module rscs_top #(
  parameter int WD_TMO_CYC = rscs_pkg::RSCS_WD_TMO_DEF,
  parameter int TEXT_CYC = rscs_pkg::RSCS_TEXT_CYC,
  parameter int WD_PULSE_CYC = rscs_pkg::RSCS_WD_PULSE_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic reset_pin_n_i,
  input wire logic dbg_reset_i,
  input wire logic dbg_enabled_i,
  input wire logic chip_erase_i,
  input wire logic undervolt_i,
  input wire logic xosc_fail_i,
  input wire logic pll_fail_i,
  output logic sys_rst_o,
  output logic cpu_halt_o,
  output logic uv_force_o,
  output logic [2:0] uv_level_o,
  output logic [4:0] clk_src_en_o,
  output logic [2:0] clk_sel_o,
  output logic [3:0] clk_presc_o,
  output logic nmi_o,
  output logic irq_o
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    rscs_pkg::rscs_pin_e pin_st;
    logic [15:0] pin_cnt;
    logic [15:0] wd_pulse_cnt;
    logic [31:0] wd_cnt;
    logic wd_en;
    logic fmon_en;
    logic uv_en;
    logic sw_req;
    rscs_pkg::rscs_clk_s clk;
    rscs_pkg::rscs_src_s src;
    logic [rscs_pkg::RSCS_NSTAT-1:0] stat;
    logic [rscs_pkg::RSCS_NSTAT-1:0] mask;
    logic sys_rst;
    logic halt;
    logic nmi;
    logic irq;
    logic uv_force;
    logic [2:0] uv_level;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } rscs_state_s;

  rscs_state_s state_reg;
  rscs_state_s state_next;

  logic wr_acc;
  logic rd_acc;
  logic osc_fail;
  logic [rscs_pkg::RSCS_NSTAT-1:0] ev;

  // ****************************************
  // Bus and failure decode
  // ****************************************
  // One write or read per access, none while pready stands
  assign wr_acc = psel_i && penable_i && pwrite_i && !state_reg.pready;
  assign rd_acc = psel_i && penable_i && !pwrite_i && !state_reg.pready;
  assign osc_fail = state_reg.fmon_en && (xosc_fail_i || pll_fail_i);

  always_comb
  begin
    state_next = state_reg;
    ev = '0;
    state_next.pready = 1'b0;
    state_next.pslverr = 1'b0;

    // ****************************************
    // Pin reset filter
    // ****************************************
    state_next.src.pin = 1'b0;
    case (state_reg.pin_st)
      rscs_pkg::RSCS_PIN_IDLE:
      begin
        state_next.pin_cnt = '0;
        if (!reset_pin_n_i)
        begin
          state_next.pin_st = rscs_pkg::RSCS_PIN_FILT;
        end
      end
      // Short pulses go back to idle without a reset
      rscs_pkg::RSCS_PIN_FILT:
      begin
        if (reset_pin_n_i)
        begin
          state_next.pin_st = rscs_pkg::RSCS_PIN_IDLE;
        end
        else if (32'(state_reg.pin_cnt) >= TEXT_CYC)
        begin
          state_next.pin_st = rscs_pkg::RSCS_PIN_HOLD;
          state_next.src.pin = 1'b1;
        end
        else
        begin
          state_next.pin_cnt = state_reg.pin_cnt + 16'h0001;
        end
      end
      rscs_pkg::RSCS_PIN_HOLD:
      begin
        state_next.src.pin = !reset_pin_n_i;
        if (reset_pin_n_i)
        begin
          state_next.pin_st = rscs_pkg::RSCS_PIN_IDLE;
        end
      end
      default:
      begin
        state_next.pin_st = rscs_pkg::RSCS_PIN_IDLE;
      end
    endcase

    // ****************************************
    // Watchdog
    // ****************************************
    // Pulse runs out even after reset clears the enable
    state_next.src.wdog = state_reg.wd_pulse_cnt != '0;
    if (state_reg.wd_pulse_cnt != '0)
    begin
      state_next.wd_pulse_cnt = state_reg.wd_pulse_cnt - 16'h0001;
    end
    if (state_reg.wd_en)
    begin
      if (32'(state_reg.wd_cnt) >= WD_TMO_CYC - 1)
      begin
        state_next.wd_cnt = '0;
        state_next.wd_pulse_cnt = 16'(WD_PULSE_CYC);
      end
      else
      begin
        state_next.wd_cnt = state_reg.wd_cnt + 32'h0000_0001;
      end
    end

    // ****************************************
    // Software and debug sources
    // ****************************************
    // Request waits one cycle so the write completes first
    state_next.src.sw = state_reg.sw_req;
    state_next.sw_req = 1'b0;
    state_next.src.dbg = dbg_reset_i;

    // ****************************************
    // Undervoltage monitor
    // ****************************************
    // Forced on while erasing or debugging, even if disabled
    state_next.uv_force = !state_reg.uv_en &&
      (chip_erase_i || dbg_enabled_i);
    if (state_next.uv_force)
    begin
      state_next.uv_level = rscs_pkg::RSCS_UVLVL_LOW;
    end
    else
    begin
      state_next.uv_level = '0;
    end
    state_next.src.uv = undervolt_i && (state_reg.uv_en || state_next.uv_force);

    // ****************************************
    // Reset combination
    // ****************************************
    state_next.sys_rst = |state_next.src;
    state_next.halt = state_reg.sw_req || state_next.sys_rst;

    // ****************************************
    // Oscillator failure
    // ****************************************
    if (osc_fail)
    begin
      state_next.nmi = 1'b1;
      state_next.clk.sel = rscs_pkg::RSCS_SRC_RC2M;
    end

    // ****************************************
    // APB slave
    // ****************************************
    if (psel_i && penable_i && !state_reg.pready)
    begin
      state_next.pready = 1'b1;
    end
    if (wr_acc)
    begin
      case (paddr_i)
        rscs_pkg::RSCS_OFS_CTRL:
        begin
          if (pwdata_i[rscs_pkg::RSCS_CTRL_SWRST])
          begin
            state_next.sw_req = 1'b1;
            state_next.halt = 1'b1;
          end
          state_next.wd_en = pwdata_i[rscs_pkg::RSCS_CTRL_WDEN];
          if (pwdata_i[rscs_pkg::RSCS_CTRL_WDRESTART])
          begin
            state_next.wd_cnt = '0;
          end
          state_next.fmon_en = pwdata_i[rscs_pkg::RSCS_CTRL_FMON];
          state_next.uv_en = pwdata_i[rscs_pkg::RSCS_CTRL_UVEN];
        end
        rscs_pkg::RSCS_OFS_CLK:
        begin
          // A standing failure wins over the write and the nmi clear
          if (!osc_fail)
          begin
            state_next.clk = pwdata_i[11:0];
            state_next.nmi = 1'b0;
          end
        end
        rscs_pkg::RSCS_OFS_MASK:
        begin
          state_next.mask = pwdata_i[rscs_pkg::RSCS_NSTAT-1:0];
        end
        rscs_pkg::RSCS_OFS_STAT:
        begin
        end
        default:
        begin
          state_next.pslverr = 1'b1;
        end
      endcase
    end
    if (rd_acc)
    begin
      case (paddr_i)
        rscs_pkg::RSCS_OFS_CTRL:
        begin
          state_next.prdata = {27'h000_0000, state_reg.uv_en,
            state_reg.fmon_en, 1'b0, state_reg.wd_en, 1'b0};
        end
        rscs_pkg::RSCS_OFS_CLK:
        begin
          state_next.prdata = {20'h0_0000, state_reg.clk};
        end
        rscs_pkg::RSCS_OFS_STAT:
        begin
          state_next.prdata = {26'h000_0000, state_reg.stat};
        end
        rscs_pkg::RSCS_OFS_MASK:
        begin
          state_next.prdata = {26'h000_0000, state_reg.mask};
        end
        rscs_pkg::RSCS_OFS_WDOG:
        begin
          state_next.prdata = state_reg.wd_cnt;
        end
        default:
        begin
          state_next.prdata = '0;
          state_next.pslverr = 1'b1;
        end
      endcase
    end

    // ****************************************
    // Sticky status, set wins over read clear
    // ****************************************
    ev[rscs_pkg::RSCS_ST_PIN] = state_next.src.pin;
    ev[rscs_pkg::RSCS_ST_WDOG] = state_next.src.wdog;
    ev[rscs_pkg::RSCS_ST_SW] = state_next.src.sw;
    ev[rscs_pkg::RSCS_ST_DBG] = state_next.src.dbg;
    ev[rscs_pkg::RSCS_ST_UV] = state_next.src.uv;
    ev[rscs_pkg::RSCS_ST_OSCF] = osc_fail;
    if (rd_acc && paddr_i == rscs_pkg::RSCS_OFS_STAT)
    begin
      state_next.stat = ev;
    end
    else
    begin
      state_next.stat = state_reg.stat | ev;
    end
    state_next.irq = |(state_next.stat & state_next.mask);

    // ****************************************
    // Reset effect on clocks, watchdog, failure monitor and nmi
    // ****************************************
    if (state_next.sys_rst)
    begin
      state_next.clk.src_en = rscs_pkg::RSCS_ENA_ULP_ONLY;
      state_next.clk.sel = rscs_pkg::RSCS_SRC_RC2M;
      state_next.clk.presc = rscs_pkg::RSCS_PRESC_RST;
      state_next.wd_en = 1'b0;
      state_next.wd_cnt = '0;
      state_next.fmon_en = 1'b0;
      state_next.nmi = 1'b0;
    end
  end

  // ****************************************
  // Registers
  // ****************************************

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_reg <= '0;
      state_reg.clk.src_en <= rscs_pkg::RSCS_ENA_ULP_ONLY;
      state_reg.clk.sel <= rscs_pkg::RSCS_SRC_RC2M;
      state_reg.sys_rst <= 1'b1;
      state_reg.halt <= 1'b1;
      state_reg.pin_st <= rscs_pkg::RSCS_PIN_IDLE;
    end
    else if (ce_i)
    begin
      state_reg <= state_next;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************

  assign prdata_o = state_reg.prdata;
  assign pready_o = state_reg.pready;
  assign pslverr_o = state_reg.pslverr;
  assign sys_rst_o = state_reg.sys_rst;
  assign cpu_halt_o = state_reg.halt;
  assign uv_force_o = state_reg.uv_force;
  assign uv_level_o = state_reg.uv_level;
  assign clk_src_en_o = state_reg.clk.src_en;
  assign clk_sel_o = state_reg.clk.sel;
  assign clk_presc_o = state_reg.clk.presc;
  assign nmi_o = state_reg.nmi;
  assign irq_o = state_reg.irq;

endmodule : rscs_top
`default_nettype wire

// ### rscs_properties.sv
`timescale 1ns/1ns
`default_nettype none
module rscs_properties #(
  parameter int TEXT_CYC = rscs_pkg::RSCS_TEXT_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic reset_pin_n_i,
  input wire logic dbg_reset_i,
  input wire logic dbg_enabled_i,
  input wire logic chip_erase_i,
  input wire logic sys_rst_o,
  input wire logic cpu_halt_o,
  input wire logic uv_force_o,
  input wire logic [2:0] uv_level_o,
  input wire logic [4:0] clk_src_en_o,
  input wire logic [2:0] clk_sel_o,
  input wire logic [3:0] clk_presc_o,
  input wire logic nmi_o
);
  // ****************************************
  // Checks
  // ****************************************
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [7:0] low_reg;
  logic sw_wr;
  assign sw_wr = psel_i && penable_i && pwrite_i && pready_o &&
    paddr_i == rscs_pkg::RSCS_OFS_CTRL && pwdata_i[rscs_pkg::RSCS_CTRL_SWRST];
  // Cycles the pin has been low
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      low_reg <= 8'h00;
    else if (reset_pin_n_i)
      low_reg <= 8'h00;
    else if (low_reg != 8'hFF)
      low_reg <= low_reg + 8'h01;
  end
  sw_reset_a: assert property (sw_wr |-> cpu_halt_o ##1 sys_rst_o)
    else $error("software reset late");
  pin_hold_a: assert property (
    !reset_pin_n_i && low_reg > TEXT_CYC + 2 |-> sys_rst_o)
    else $error("pin reset not held");
  dbg_follow_a: assert property (
    dbg_reset_i && ce_i |=> sys_rst_o)
    else $error("debug reset not passed on");
  clk_ulp_a: assert property (
    sys_rst_o ##1 sys_rst_o |-> clk_src_en_o == rscs_pkg::RSCS_ENA_ULP_ONLY)
    else $error("clock sources not cut in reset");
  clk_boot_a: assert property (
    $fell(sys_rst_o) |-> clk_sel_o == rscs_pkg::RSCS_SRC_RC2M &&
    clk_presc_o == rscs_pkg::RSCS_PRESC_RST)
    else $error("boot clock wrong");
  nmi_fallback_a: assert property (
    $rose(nmi_o) |-> ##[0:1] clk_sel_o != rscs_pkg::RSCS_SRC_XOSC &&
    clk_sel_o != rscs_pkg::RSCS_SRC_PLL)
    else $error("no fallback on failure");
  uv_force_a: assert property (
    (ce_i && (dbg_enabled_i || chip_erase_i)) [*2] |-> uv_force_o &&
    uv_level_o == rscs_pkg::RSCS_UVLVL_LOW)
    else $error("monitor not forced");
  pready_pulse_a: assert property (pready_o |=> !pready_o)
    else $error("pready longer than one cycle");
  err_qual_a: assert property (pslverr_o |-> pready_o && psel_i && penable_i)
    else $error("pslverr outside answer");
  sw_c: cover property (sw_wr);
  dbg_c: cover property (dbg_reset_i ##1 sys_rst_o);
  uv_c: cover property (uv_force_o);
  nmi_c: cover property ($rose(nmi_o));
endmodule : rscs_properties
bind rscs_top rscs_properties #(.TEXT_CYC(TEXT_CYC)) rscs_properties_i (
  .clk_i, .rst_i, .ce_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
  .pready_o, .pslverr_o, .reset_pin_n_i, .dbg_reset_i, .dbg_enabled_i,
  .chip_erase_i, .sys_rst_o, .cpu_halt_o, .uv_force_o, .uv_level_o,
  .clk_src_en_o, .clk_sel_o, .clk_presc_o, .nmi_o);
`default_nettype wire

// ### rscs_ext.sv
`timescale 1ns/1ns
`default_nettype none
module rscs_ext (
  input wire logic clk_i,
  input wire logic go_i,
  input wire logic dbg_i,
  input wire logic [7:0] len_i,
  output logic pin_n_o,
  output logic dbg_o
);
  logic [7:0] cnt_reg = 8'h00;
  logic mode_reg = 1'b0;
  // Pin has a pull-up, idles high
  assign pin_n_o = !(cnt_reg != 8'h00 && !mode_reg);
  assign dbg_o = cnt_reg != 8'h00 && mode_reg;
  always_ff @(posedge clk_i)
  begin
    if (go_i)
    begin
      cnt_reg <= len_i;
      mode_reg <= dbg_i;
    end
    else if (cnt_reg != 8'h00)
      cnt_reg <= cnt_reg - 8'h01;
  end
endmodule : rscs_ext
`default_nettype wire

// ### reset_source_and_clock_startup_bench.sv
`timescale 1ns/1ns
`default_nettype none
module reset_source_and_clock_startup_bench;
  localparam int TX = rscs_pkg::RSCS_TEXT_CYC;
  localparam int C = rscs_pkg::RSCS_RC2M_CYC;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, go = 1'b0, mode = 1'b0;
  logic dbg_en = 1'b0, erase = 1'b0, xfail = 1'b0;
  logic pfail = 1'b0, uvin = 1'b0, ce = 1'b1;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [7:0] len = 8'h00;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, pin_n, dbg_rst, sys_rst, halt, uvf, nmi, irq;
  logic [2:0] uvl, sel;
  logic [4:0] en;
  logic [3:0] presc;
  int miscompares = 0, n_compared = 0, cyc = 0, h, g;
  rscs_top #(.WD_TMO_CYC(50)) rscs_top_i (.clk_i, .rst_i, .ce_i(ce),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .reset_pin_n_i(pin_n), .dbg_reset_i(dbg_rst),
    .dbg_enabled_i(dbg_en), .chip_erase_i(erase), .undervolt_i(uvin),
    .xosc_fail_i(xfail), .pll_fail_i(pfail), .sys_rst_o(sys_rst),
    .cpu_halt_o(halt), .uv_force_o(uvf), .uv_level_o(uvl),
    .clk_src_en_o(en), .clk_sel_o(sel), .clk_presc_o(presc), .nmi_o(nmi),
    .irq_o(irq));
  rscs_ext rscs_ext_i (.clk_i, .go_i(go), .dbg_i(mode), .len_i(len),
    .pin_n_o(pin_n), .dbg_o(dbg_rst));
  // ****************************************
  // Helpers
  // ****************************************
  task automatic results;
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : results
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    n_compared++;
    if (s !== x)
    begin
      miscompares++;
      $display("Error t=%0t seen %h exp %h", $time, s, x);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i) {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge clk_i) penable <= 1'b1;
    @(posedge clk_i);
    while (pready !== 1'b1 && n < 50)
    begin
      @(posedge clk_i);
      n++;
    end
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
    chk(n < 50, 1);
  endtask : apb
  task automatic run(input int n);
    h = 0;
    repeat (n) @(posedge clk_i) #1 h += (sys_rst === 1'b1);
  endtask : run
  task automatic pulse(input logic m, input logic [7:0] l);
    @(posedge clk_i) {go, mode, len} <= {1'b1, m, l};
    @(posedge clk_i) go <= 1'b0;
  endtask : pulse
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_pin;
    pulse(1'b0, 8'h05);
    run(30);
    chk(h, 0);
    pulse(1'b0, 8'h28);
    run(60);
    chk(h >= 39 - TX && h <= 41 - TX, 1);
  endtask : t_pin
  task automatic t_dbg;
    @(posedge clk_i) ce <= 1'b0;
    pulse(1'b1, 8'h14);
    run(30);
    chk(h, 0);
    @(posedge clk_i) ce <= 1'b1;
    pulse(1'b1, 8'h14);
    run(40);
    chk(h >= 19 && h <= 21, 1);
  endtask : t_dbg
  task automatic t_sw;
    apb(1'b0, rscs_pkg::RSCS_OFS_STAT, 32'h0000_0000);
    apb(1'b1, rscs_pkg::RSCS_OFS_CLK, 32'h0000_08BF);
    #1 chk(sel, 3'h4);
    chk(presc, 4'h5);
    apb(1'b1, rscs_pkg::RSCS_OFS_CTRL, 32'h0000_0001);
    #1 chk(halt, 1);
    chk(sys_rst, 1);
    run(10);
    chk(sel, rscs_pkg::RSCS_SRC_RC2M);
    chk(en, rscs_pkg::RSCS_ENA_ULP_ONLY);
    chk(presc, rscs_pkg::RSCS_PRESC_RST);
    apb(1'b0, rscs_pkg::RSCS_OFS_STAT, 32'h0000_0000);
    chk(rd[5:0], 6'h04);
  endtask : t_sw
  task automatic t_wd;
    g = 0;
    apb(1'b1, rscs_pkg::RSCS_OFS_CTRL, 32'h0000_0002);
    repeat (3)
    begin
      run(30);
      g += h;
      apb(1'b1, rscs_pkg::RSCS_OFS_CTRL, 32'h0000_0006);
    end
    chk(g, 0);
    run(300);
    chk(h >= C && h <= 2 * C, 1);
    apb(1'b0, rscs_pkg::RSCS_OFS_STAT, 32'h0000_0000);
    chk(rd[5:0], 6'h02);
  endtask : t_wd
  task automatic t_fail;
    apb(1'b1, rscs_pkg::RSCS_OFS_MASK, 32'h0000_0000);
    apb(1'b1, rscs_pkg::RSCS_OFS_CTRL, 32'h0000_0008);
    apb(1'b1, rscs_pkg::RSCS_OFS_CLK, 32'h0000_061F);
    @(posedge clk_i) xfail <= 1'b1;
    run(5);
    chk(nmi, 1);
    chk(sel, rscs_pkg::RSCS_SRC_RC2M);
    chk(irq, 0);
    apb(1'b1, rscs_pkg::RSCS_OFS_MASK, 32'h0000_0020);
    #1 chk(irq, 1);
    @(posedge clk_i) xfail <= 1'b0;
    apb(1'b0, rscs_pkg::RSCS_OFS_STAT, 32'h0000_0000);
    chk(rd[5:0], 6'h20);
    run(2);
    chk(irq, 0);
    apb(1'b1, rscs_pkg::RSCS_OFS_CLK, 32'h0000_0010);
    #1 chk(nmi, 0);
    apb(1'b1, rscs_pkg::RSCS_OFS_CLK, 32'h0000_081F);
    #1 chk(sel, rscs_pkg::RSCS_SRC_PLL);
    @(posedge clk_i) pfail <= 1'b1;
    run(5);
    chk(nmi, 1);
    chk(sel, rscs_pkg::RSCS_SRC_RC2M);
    @(posedge clk_i) pfail <= 1'b0;
    apb(1'b0, rscs_pkg::RSCS_OFS_STAT, 32'h0000_0000);
    chk(rd[5:0], 6'h20);
    apb(1'b1, rscs_pkg::RSCS_OFS_CLK, 32'h0000_0010);
    #1 chk(nmi, 0);
  endtask : t_fail
  task automatic t_uv;
    @(posedge clk_i) dbg_en <= 1'b1;
    run(3);
    chk({uvf, uvl}, 4'hF);
    @(posedge clk_i) {dbg_en, erase} <= 2'b01;
    run(3);
    chk({uvf, uvl}, 4'hF);
    @(posedge clk_i) uvin <= 1'b1;
    run(3);
    chk(sys_rst, 1);
    @(posedge clk_i) {erase, uvin} <= 2'b00;
    run(3);
    chk({uvf, uvl}, 4'h0);
  endtask : t_uv
  task automatic t_bus;
    apb(1'b0, 12'h020, 32'h0000_0000);
    chk(err, 1);
    apb(1'b0, rscs_pkg::RSCS_OFS_MASK, 32'h0000_0000);
    chk({err, rd}, 33'h0_0000_0020);
  endtask : t_bus
  initial forever #5 clk_i = ~clk_i;
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      miscompares++;
      results();
    end
  end
  initial
  begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    run(5);
    t_pin();
    t_dbg();
    t_sw();
    t_wd();
    t_fail();
    t_uv();
    t_bus();
    results();
  end
endmodule : reset_source_and_clock_startup_bench
`default_nettype wire
